// [verilog/acc_pkg.sv]
package acc_pkg;
  // Register offsets on the plain register port.
  localparam logic [7:0] ACC_ADDR_CONTROL = 8'hAD;
  localparam logic [7:0] ACC_ADDR_RESULT_LOW = 8'hAE;
  localparam logic [7:0] ACC_ADDR_RESULT_HIGH = 8'hAF;
  localparam logic [7:0] ACC_ADDR_CONFIG = 8'hB0;
  // Control register field positions.
  localparam int ACC_BIT_POWER = 7;
  localparam int ACC_BIT_START = 6;
  localparam int ACC_BIT_FLAG = 5;
  localparam int ACC_SEL_MSB = 4;
  // Configuration register field positions.
  localparam int ACC_BIT_IRQ_EN = 6;
  localparam int ACC_REF_MSB = 1;
  // Reset values.
  localparam logic [7:0] ACC_CONTROL_RESET = 8'h00;
  localparam logic [1:0] ACC_REF_RESET = 2'h0;
  // Input-select codes.
  localparam logic [4:0] ACC_SEL_LAST_EXT = 5'h0B;
  localparam logic [4:0] ACC_SEL_QUARTER = 5'h1F;
  // Reference choices.
  localparam logic [1:0] ACC_REF_SUPPLY = 2'h0;
  localparam logic [1:0] ACC_REF_2V048 = 2'h1;
  localparam logic [1:0] ACC_REF_1V024 = 2'h2;
  localparam logic [1:0] ACC_REF_2V4 = 2'h3;
  // Channel counts and result width.
  localparam int ACC_EXT_CHANNELS = 12;
  localparam int ACC_RESULT_W = 12;
  // Conversion timing at 200 MHz.
  localparam int ACC_CLK_PERIOD_PS = 5000;
  localparam int ACC_CONV_TIME_NS = 950;
  localparam int ACC_CONV_CYCLES = (ACC_CONV_TIME_NS * 1000 + ACC_CLK_PERIOD_PS - 1)
                                   / ACC_CLK_PERIOD_PS;
  typedef enum logic [1:0] {
    ACC_IDLE = 2'b01,
    ACC_BUSY = 2'b10
  } acc_state_e;
endpackage

// [verilog/acc_result_store.sv]
`timescale 1ns/10ps
module acc_result_store
  import acc_pkg::*;
#(
  parameter int WIDTH = ACC_RESULT_W
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Capture side.
  input wire logic load_i,
  input wire logic [WIDTH-1:0] value_i,
  // Stored value.
  output logic [WIDTH-1:0] value_o
);
  logic [WIDTH-1:0] value_r;
  logic [WIDTH-1:0] value_nxt;

  always_comb begin
    value_nxt = value_r;
    if (load_i) begin
      value_nxt = value_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      value_r <= '0;
    end else begin
      value_r <= value_nxt;
    end
  end

  assign value_o = value_r;
endmodule

// [verilog/acc_control.sv]
`timescale 1ns/10ps
module acc_control
  import acc_pkg::*;
#(
  parameter int CONV_CYCLES = ACC_CONV_CYCLES
) (
  // Clock and reset.
  input wire logic CLOCK_I,
  input wire logic RST_N_I,
  // Register port.
  input wire logic [7:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [7:0] RDATA_O,
  // Analog core.
  output logic POWER_ON_O,
  output logic SAMPLE_START_O,
  output logic [ACC_EXT_CHANNELS-1:0] ANALOG_INPUT_N_SEL_O,
  output logic QUARTER_SUPPLY_SEL_O,
  output logic [3:0] REFERENCE_ONEHOT_O,
  input wire logic [ACC_RESULT_W-1:0] CORE_RESULT_I,
  // Interrupt request to the CPU.
  output logic IRQ_O
);
  localparam int CW = $clog2(CONV_CYCLES + 1);
  localparam logic [CW-1:0] CONV_LAST = CW'(CONV_CYCLES - 1);

  acc_state_e state_r, state_nxt;
  logic [CW-1:0] count_r, count_nxt;
  logic power_r, power_nxt;
  logic flag_r, flag_nxt;
  logic [4:0] sel_r, sel_nxt;
  logic [4:0] conv_sel_r, conv_sel_nxt;
  logic irq_en_r, irq_en_nxt;
  logic [1:0] ref_r, ref_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic start_pulse_r, start_pulse_nxt;
  logic wr_ctl;
  logic start_req;
  logic done;
  logic [ACC_RESULT_W-1:0] result;

  function automatic logic [ACC_EXT_CHANNELS-1:0] ext_decode(input logic [4:0] code);
    ext_decode = '0;
    if (code <= ACC_SEL_LAST_EXT) begin
      ext_decode[code[3:0]] = 1'b1;
    end
  endfunction

  assign wr_ctl = WR_I && (ADDR_I == ACC_ADDR_CONTROL);
  assign start_req = wr_ctl && WDATA_I[ACC_BIT_START] && WDATA_I[ACC_BIT_POWER];
  assign done = (state_r == ACC_BUSY) && (count_r == CONV_LAST);

  always_comb begin
    state_nxt = state_r;
    count_nxt = count_r;
    start_pulse_nxt = 1'b0;
    conv_sel_nxt = conv_sel_r;
    unique case (state_r)
      ACC_IDLE: begin
        if (start_req) begin
          state_nxt = ACC_BUSY;
          count_nxt = '0;
          start_pulse_nxt = 1'b1;
          conv_sel_nxt = WDATA_I[ACC_SEL_MSB:0];
        end
      end
      ACC_BUSY: begin
        count_nxt = count_r + CW'(1);
        if (!power_r) begin
          state_nxt = ACC_IDLE;
        end else if (done) begin
          state_nxt = ACC_IDLE;
        end
      end
      default: begin
        state_nxt = ACC_IDLE;
      end
    endcase
  end

  always_comb begin
    power_nxt = power_r;
    sel_nxt = sel_r;
    flag_nxt = flag_r;
    irq_en_nxt = irq_en_r;
    ref_nxt = ref_r;
    if (wr_ctl) begin
      power_nxt = WDATA_I[ACC_BIT_POWER];
      sel_nxt = WDATA_I[ACC_SEL_MSB:0];
      flag_nxt = WDATA_I[ACC_BIT_FLAG];
    end
    if (start_req) begin
      flag_nxt = 1'b0;
    end
    if (done && power_r) begin
      flag_nxt = 1'b1;
    end
    if (WR_I && (ADDR_I == ACC_ADDR_CONFIG)) begin
      irq_en_nxt = WDATA_I[ACC_BIT_IRQ_EN];
      ref_nxt = WDATA_I[ACC_REF_MSB:0];
    end
  end

  always_comb begin
    rdata_nxt = 8'h00;
    if (RD_I) begin
      unique case (ADDR_I)
        ACC_ADDR_CONTROL: rdata_nxt = {power_r, 1'b0, flag_r, sel_r};
        ACC_ADDR_RESULT_HIGH: rdata_nxt = result[ACC_RESULT_W-1:4];
        ACC_ADDR_RESULT_LOW: rdata_nxt = {result[3:0], 4'h0};
        ACC_ADDR_CONFIG: rdata_nxt = {1'b0, irq_en_r, 4'h0, ref_r};
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_r <= ACC_IDLE;
      count_r <= '0;
      power_r <= ACC_CONTROL_RESET[ACC_BIT_POWER];
      flag_r <= ACC_CONTROL_RESET[ACC_BIT_FLAG];
      sel_r <= ACC_CONTROL_RESET[ACC_SEL_MSB:0];
      conv_sel_r <= ACC_CONTROL_RESET[ACC_SEL_MSB:0];
      irq_en_r <= 1'b0;
      ref_r <= ACC_REF_RESET;
      rdata_r <= 8'h00;
      start_pulse_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      count_r <= count_nxt;
      power_r <= power_nxt;
      flag_r <= flag_nxt;
      sel_r <= sel_nxt;
      conv_sel_r <= conv_sel_nxt;
      irq_en_r <= irq_en_nxt;
      ref_r <= ref_nxt;
      rdata_r <= rdata_nxt;
      start_pulse_r <= start_pulse_nxt;
    end
  end

  acc_result_store #(
    .WIDTH(ACC_RESULT_W)
  ) u_store (
    .clk_i(CLOCK_I),
    .rst_n_i(RST_N_I),
    .load_i(done && power_r),
    .value_i(CORE_RESULT_I),
    .value_o(result)
  );

  assign RDATA_O = rdata_r;
  assign POWER_ON_O = power_r;
  assign SAMPLE_START_O = start_pulse_r;
  assign ANALOG_INPUT_N_SEL_O = ext_decode(conv_sel_r);
  assign QUARTER_SUPPLY_SEL_O = (conv_sel_r == ACC_SEL_QUARTER);
  assign REFERENCE_ONEHOT_O = {ref_r == ACC_REF_2V4, ref_r == ACC_REF_1V024,
                               ref_r == ACC_REF_2V048, ref_r == ACC_REF_SUPPLY};
  assign IRQ_O = flag_r && irq_en_r;

  property p_start_clears;
    @(posedge CLOCK_I) disable iff (!RST_N_I)
      start_req && state_r == ACC_IDLE |=> !flag_r;
  endproperty
  a_start_clears: assert property (p_start_clears) else $error("flag not cleared");

  sequence s_started;
    start_req && state_r == ACC_IDLE;
  endsequence
  sequence s_powered_run;
    (power_r && !wr_ctl) [*1];
  endsequence
  property p_done_sets;
    @(posedge CLOCK_I) disable iff (!RST_N_I)
      done && power_r |=> flag_r;
  endproperty
  a_done_sets: assert property (p_done_sets) else $error("flag not set");

  property p_busy_len;
    @(posedge CLOCK_I) disable iff (!RST_N_I)
      s_started ##1 s_powered_run |-> state_r == ACC_BUSY;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("not busy after start");

  property p_no_power_no_flag;
    @(posedge CLOCK_I) disable iff (!RST_N_I)
      !power_r && !wr_ctl && !flag_r |=> !flag_r;
  endproperty
  a_no_power_no_flag: assert property (p_no_power_no_flag) else $error("flag set unpowered");

  property p_flag_sticky;
    @(posedge CLOCK_I) disable iff (!RST_N_I)
      flag_r && !wr_ctl |=> flag_r;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost");

  property p_irq_gate;
    @(posedge CLOCK_I) disable iff (!RST_N_I)
      WR_I && (ADDR_I == ACC_ADDR_CONFIG) |=>
        IRQ_O == ($past(WDATA_I[ACC_BIT_IRQ_EN]) && flag_r);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq gating wrong");

  property p_power_follows;
    @(posedge CLOCK_I) disable iff (!RST_N_I)
      wr_ctl |=> POWER_ON_O == $past(WDATA_I[ACC_BIT_POWER]);
  endproperty
  a_power_follows: assert property (p_power_follows) else $error("power bit wrong");

  property p_result_with_flag;
    @(posedge CLOCK_I) disable iff (!RST_N_I)
      done && power_r |=> result == $past(CORE_RESULT_I);
  endproperty
  a_result_with_flag: assert property (p_result_with_flag) else $error("result late");

  property p_quarter;
    @(posedge CLOCK_I) disable iff (!RST_N_I)
      QUARTER_SUPPLY_SEL_O |-> ANALOG_INPUT_N_SEL_O == '0;
  endproperty
  a_quarter: assert property (p_quarter) else $error("two inputs routed");
endmodule

// [test/acc_core_model.sv]
`timescale 1ns/10ps
module acc_core_model
  import acc_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Control from the block.
  input wire logic power_on_i,
  input wire logic [ACC_EXT_CHANNELS-1:0] input_sel_i,
  input wire logic quarter_sel_i,
  // Result to the block.
  output logic [ACC_RESULT_W-1:0] result_o
);
  logic [ACC_RESULT_W-1:0] result_nxt;
  always_comb begin
    result_nxt = input_sel_i ^ {ACC_RESULT_W{quarter_sel_i}} ^ 12'h5A0;
    if (!power_on_i) begin
      result_nxt = ~result_o;
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      result_o <= 12'h000;
    end else begin
      result_o <= result_nxt;
    end
  end
endmodule

// [test/acc_control_test.sv]
`timescale 1ns/10ps
module acc_control_test;
  import acc_pkg::*;
  localparam int CONV = 4;
  logic clk, rst_n, wr, rd, pwr, start, quarter, irq;
  logic [7:0] addr, wdata, rdata, v;
  logic [11:0] sel, result, e;
  logic [3:0] ref_oh;
  int fails, comparisons;
  acc_control #(.CONV_CYCLES(CONV)) uut (.CLOCK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .POWER_ON_O(pwr),
    .SAMPLE_START_O(start), .ANALOG_INPUT_N_SEL_O(sel), .QUARTER_SUPPLY_SEL_O(quarter),
    .REFERENCE_ONEHOT_O(ref_oh), .CORE_RESULT_I(result), .IRQ_O(irq));
  acc_core_model core (.clk_i(clk), .rst_n_i(rst_n), .power_on_i(pwr), .input_sel_i(sel),
    .quarter_sel_i(quarter), .result_o(result));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string name);
    rd_reg(a);
    chk(name, {4'h0, exp}, {4'h0, v});
  endtask
  task automatic wait_flag();
    for (int i = 0; i < 20; i++) begin
      rd_reg(ACC_ADDR_CONTROL);
      if (v[ACC_BIT_FLAG] === 1'b1) begin
        return;
      end
    end
    fails++;
    $display("ERROR flag_wait expected 1 seen 0");
    wrap_up();
  endtask
  initial begin
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    fails = 0;
    comparisons = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    chk("ref_reset", 12'h001, {8'h00, ref_oh});
    rd_chk(ACC_ADDR_CONTROL, ACC_CONTROL_RESET, "control_reset");
    rd_chk(ACC_ADDR_CONFIG, 8'h00, "config_reset");
    rd_chk(ACC_ADDR_RESULT_HIGH, 8'h00, "result_reset");
    rd_chk(8'h00, 8'h00, "unmapped");
    wr_reg(ACC_ADDR_CONTROL, 8'h40);
    #1 chk("start_unpowered", 12'h000, {11'h000, start});
    chk("power_off", 12'h000, {11'h000, pwr});
    repeat (CONV + 4) @(posedge clk);
    rd_chk(ACC_ADDR_CONTROL, 8'h00, "flag_unpowered");
    for (int c = 0; c < 32; c++) begin
      if (c < 13 || c == 31) begin
        wr_reg(ACC_ADDR_CONTROL, 8'hC0 | 8'(c));
        #1 chk("start_pulse", 12'h001, {11'h000, start});
        chk("power_on", 12'h001, {11'h000, pwr});
        wait_flag();
        chk("control", {4'h0, 8'hA0 | 8'(c)}, {4'h0, v});
        e = (c < 12 ? 12'h001 << c : 12'h000) ^ (c == 31 ? 12'hFFF : 12'h000) ^ 12'h5A0;
        rd_chk(ACC_ADDR_RESULT_HIGH, e[11:4], "result_high");
        rd_chk(ACC_ADDR_RESULT_LOW, {e[3:0], 4'h0}, "result_low");
        chk("input_route", (c < 12 ? 12'h001 << c : 12'h000), sel);
        chk("quarter_route", {11'h000, c == 31}, {11'h000, quarter});
        chk("irq_disabled", 12'h000, {11'h000, irq});
      end
    end
    for (int r = 0; r < 4; r++) begin
      wr_reg(ACC_ADDR_CONFIG, 8'h40 | 8'(r));
      #1 chk("reference", 12'h001 << r, {8'h00, ref_oh});
      chk("irq_on", 12'h001, {11'h000, irq});
    end
    wr_reg(ACC_ADDR_CONFIG, 8'h00);
    #1 chk("irq_masked", 12'h000, {11'h000, irq});
    rd_chk(ACC_ADDR_CONTROL, 8'hBF, "flag_held");
    @(posedge clk);
    #1 chk("rdata_idle", 12'h000, {4'h0, rdata});
    wr_reg(ACC_ADDR_CONTROL, 8'h9F);
    rd_chk(ACC_ADDR_CONTROL, 8'h9F, "flag_cleared");
    wr_reg(ACC_ADDR_CONTROL, 8'hBF);
    wr_reg(ACC_ADDR_CONTROL, 8'hE3);
    rd_chk(ACC_ADDR_CONTROL, 8'h83, "start_clears");
    wait_flag();
    chk("flag_again", 12'h0A3, {4'h0, v});
    wrap_up();
  end
endmodule
